// >>> common/adccf_pkg.sv
// Constants and types shared by the conversion control block
package adccf_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int RES_W = 12;
  localparam int BUS_W = 12;
  localparam int CTRL_W = 10;
  localparam int FIFO_DEPTH = 16;
  // ---------------------------------------------------------------
  // Control register select and fields
  // ---------------------------------------------------------------
  localparam int ADDR_BIT = 10;
  localparam int CH_EN_LSB = 0;
  localparam int MODE_BIT = 4;
  localparam int DIFF_LSB = 5;
  localparam int SCAN_BIT = 7;
  localparam int POL_BIT = 0;
  localparam int PULSE_BIT = 1;
  localparam int TRIG_LSB = 2;
  localparam int TRIG_W = 4;
  localparam int FLUSH_BIT = 6;
  localparam logic [9:0] CTRL0_RESET = 10'h001;
  localparam logic [9:0] CTRL1_RESET = 10'h000;
  // ---------------------------------------------------------------
  // Timing counts and sequencer states
  // ---------------------------------------------------------------
  localparam int OSC_DIV = 4;
  localparam int CONV_TICKS = 6;
  typedef enum logic [1:0] {
    ADCCF_IDLE = 2'b00,
    ADCCF_CONV = 2'b01,
    ADCCF_WRITE = 2'b10
  } adccf_state_t;
endpackage : adccf_pkg

// >>> core/adccf_top.sv
// Conversion control, result FIFO and parallel port logic

// ---------------------------------------------------------------
// Result FIFO
// ---------------------------------------------------------------
module adccf_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_flush,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [CW-1:0] count_reg;
  logic do_wr, do_rd;
  assign o_wr_ready = count_reg != CW'(DEPTH);
  assign o_rd_valid = count_reg != '0;
  assign o_rd_data = mem[rp_reg];
  assign o_count = count_reg;
  assign do_wr = i_wr_valid & o_wr_ready;
  assign do_rd = i_rd_ready & o_rd_valid;
  always_ff @(posedge i_ref_clk) begin
    if (do_wr) begin
      mem[wp_reg] <= i_wr_data;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || i_flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      count_reg <= count_reg + CW'(do_wr) - CW'(do_rd);
    end
  end
endmodule : adccf_fifo

// ---------------------------------------------------------------
// Top
// ---------------------------------------------------------------
module adccf_top #(
  parameter int FIFO_DEPTH = adccf_pkg::FIFO_DEPTH,
  parameter int OSC_DIV = adccf_pkg::OSC_DIV,
  parameter int CONV_TICKS = adccf_pkg::CONV_TICKS
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_conversion_clock_input,
  input wire logic i_select_low_active_n,
  input wire logic i_select_high_active,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic [adccf_pkg::BUS_W-1:0] i_data,
  output logic [adccf_pkg::BUS_W-1:0] o_data,
  output logic o_data_oe_n,
  input wire logic [adccf_pkg::NUM_CH*adccf_pkg::RES_W-1:0] i_sample_data,
  output logic o_hold,
  output logic o_osc_enable,
  output logic o_conv_busy,
  output logic o_result_ready_flag
);
  import adccf_pkg::*;
  localparam int CW = $clog2(FIFO_DEPTH+1);
  logic [CTRL_W-1:0] ctrl0_reg, ctrl1_reg;
  logic flush_reg, wr_d_reg, rd_d_reg, conv_d_reg, level_d_reg;
  logic [7:0] osc_cnt_reg, tick_cnt_reg;
  logic [1:0] ch_idx_reg;
  logic [NUM_CH*RES_W-1:0] held_reg;
  adccf_state_t state_reg, state_next;
  logic sel, wr_fall, rd_fall, cont_mode, conv_fall, conv_rise, start;
  logic osc_tick, conv_tick, conv_done, push, advance, fifo_ready, fifo_valid, level, flag_active;
  logic [NUM_CH-1:0] raw_mask, sel_mask;
  logic [RES_W-1:0] fifo_data;
  logic [CW-1:0] fifo_count;

  assign sel = !i_select_low_active_n && i_select_high_active;
  assign wr_fall = sel && !i_wr_n && wr_d_reg;
  assign rd_fall = sel && !i_rd_n && rd_d_reg;
  assign cont_mode = ctrl0_reg[MODE_BIT];
  assign conv_fall = conv_d_reg && !i_conversion_clock_input;
  assign conv_rise = !conv_d_reg && i_conversion_clock_input;
  assign start = cont_mode ? conv_rise : conv_fall;
  assign osc_tick = o_osc_enable && (osc_cnt_reg == 8'(OSC_DIV-1));
  assign conv_tick = cont_mode ? conv_rise : osc_tick;
  assign conv_done = (state_reg == ADCCF_CONV) && conv_tick && (tick_cnt_reg == 8'(CONV_TICKS-1));

  // Channel selection: differential pair uses its first input only
  always_comb begin
    raw_mask = ctrl0_reg[CH_EN_LSB +: NUM_CH];
    raw_mask[1] = raw_mask[1] && !ctrl0_reg[DIFF_LSB];
    raw_mask[3] = raw_mask[3] && !ctrl0_reg[DIFF_LSB+1];
    sel_mask = ctrl0_reg[SCAN_BIT] ? raw_mask : (raw_mask & (~raw_mask + 4'h1));
  end

  // ---------------------------------------------------------------
  // Host port
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      wr_d_reg <= 1'b1;
      rd_d_reg <= 1'b1;
      conv_d_reg <= 1'b1;
    end else begin
      wr_d_reg <= i_wr_n;
      rd_d_reg <= i_rd_n;
      conv_d_reg <= i_conversion_clock_input;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ctrl0_reg <= CTRL0_RESET;
      ctrl1_reg <= CTRL1_RESET;
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= 1'b0;
      if (wr_fall) begin
        if (i_data[ADDR_BIT]) begin
          ctrl1_reg <= i_data[CTRL_W-1:0];
          flush_reg <= i_data[FLUSH_BIT];
        end else begin
          ctrl0_reg <= i_data[CTRL_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_data <= '0;
      o_data_oe_n <= 1'b1;
    end else begin
      o_data_oe_n <= !(sel && !i_rd_n);
      if (rd_fall) begin
        o_data <= fifo_valid ? BUS_W'(fifo_data) : '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ADCCF_IDLE: if (start) state_next = ADCCF_CONV;
      ADCCF_CONV: if (conv_done) state_next = ADCCF_WRITE;
      ADCCF_WRITE: if (advance && ch_idx_reg == 2'h3) state_next = ADCCF_IDLE;
      default: state_next = ADCCF_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      state_reg <= ADCCF_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      osc_cnt_reg <= '0;
      tick_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= (!o_osc_enable || osc_tick) ? '0 : osc_cnt_reg + 8'h01;
      if (state_reg != ADCCF_CONV) begin
        tick_cnt_reg <= '0;
      end else if (conv_tick) begin
        tick_cnt_reg <= tick_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_hold <= 1'b0;
      o_osc_enable <= 1'b0;
      o_conv_busy <= 1'b0;
    end else begin
      o_hold <= (state_reg == ADCCF_IDLE) && start;
      o_osc_enable <= (state_next == ADCCF_CONV) && !ctrl0_reg[MODE_BIT];
      o_conv_busy <= state_next != ADCCF_IDLE;
    end
  end

  assign push = (state_reg == ADCCF_WRITE) && sel_mask[ch_idx_reg] && fifo_ready;
  assign advance = (state_reg == ADCCF_WRITE) && (!sel_mask[ch_idx_reg] || fifo_ready);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      held_reg <= '0;
      ch_idx_reg <= '0;
    end else if (conv_done) begin
      held_reg <= i_sample_data;
      ch_idx_reg <= '0;
    end else if (advance) begin
      ch_idx_reg <= ch_idx_reg + 2'h1;
    end
  end

  adccf_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_flush(flush_reg),
    .i_wr_valid(push),
    .o_wr_ready(fifo_ready),
    .i_wr_data(held_reg[ch_idx_reg*RES_W +: RES_W]),
    .o_rd_valid(fifo_valid),
    .i_rd_ready(rd_fall),
    .o_rd_data(fifo_data),
    .o_count(fifo_count)
  );

  // ---------------------------------------------------------------
  // Ready flag
  // ---------------------------------------------------------------
  assign level = fifo_count >= (CW'(ctrl1_reg[TRIG_LSB +: TRIG_W]) + CW'(1));
  assign flag_active = ctrl1_reg[PULSE_BIT] ? (level && !level_d_reg) : level;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      level_d_reg <= 1'b0;
      o_result_ready_flag <= 1'b0;
    end else begin
      level_d_reg <= level;
      o_result_ready_flag <= ctrl1_reg[POL_BIT] ? flag_active : !flag_active;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_ctrl_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    wr_fall && !i_data[ADDR_BIT] |=> ctrl0_reg == $past(i_data[CTRL_W-1:0]))
    else $error("control write lost");
  chk_single_start: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    state_reg == ADCCF_IDLE && !cont_mode && conv_fall |=> o_hold && state_reg == ADCCF_CONV)
    else $error("single start not taken");
  chk_osc_off: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    cont_mode && $past(cont_mode) |-> !o_osc_enable)
    else $error("oscillator on in continuous mode");
  chk_osc_on: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    state_reg == ADCCF_CONV && !cont_mode && $stable(cont_mode) |-> o_osc_enable)
    else $error("oscillator off during single conversion");
  chk_fifo_bound: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    push && !rd_fall && !flush_reg |=> fifo_count == $past(fifo_count) + CW'(1) && fifo_count <= CW'(FIFO_DEPTH))
    else $error("fifo count wrong on push");
  chk_diff_mask: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ctrl0_reg[DIFF_LSB] |-> !sel_mask[1])
    else $error("differential partner converted");
  chk_scan_order: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    advance && ch_idx_reg != 2'h3 |=> ch_idx_reg == $past(ch_idx_reg) + 2'h1)
    else $error("channel order broken");
  chk_flag_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ctrl1_reg[PULSE_BIT] && $stable(ctrl1_reg) && level && $past(level) |=>
      o_result_ready_flag == !$past(ctrl1_reg[POL_BIT]))
    else $error("pulse flag not single cycle");
  chk_conv_len: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(state_reg == ADCCF_CONV) && !cont_mode |-> ##[1:200] state_reg == ADCCF_WRITE)
    else $error("conversion did not finish");
endmodule : adccf_top

// >>> tb/adccf_host_model.sv
// Host processor model on the parallel port, plus the conversion start and clock line
module adccf_host_model import adccf_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic [adccf_pkg::BUS_W-1:0] i_q,
  output logic o_conv,
  output logic o_cs_n,
  output logic o_cs,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic [adccf_pkg::BUS_W-1:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_conv = 1'b1;
    o_cs_n = 1'b1;
    o_cs = 1'b0;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_data = 12'hFFF;
  end
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  task automatic wr(input logic [11:0] v, input logic lo_n = 1'b0, input logic hi = 1'b1);
    @(posedge i_ref_clk);
    o_cs_n <= lo_n;
    o_cs <= hi;
    o_data <= v;
    o_wr_n <= 1'b0;
    @(posedge i_ref_clk);
    o_wr_n <= 1'b1;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b1;
    o_cs <= 1'b0;
    o_data <= ~v;
  endtask : wr
  task automatic rd(output logic [11:0] q);
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    o_cs <= 1'b1;
    o_rd_n <= 1'b0;
    @(posedge i_ref_clk);
    o_rd_n <= 1'b1;
    @(posedge i_ref_clk);
    q = i_q;
    o_cs_n <= 1'b1;
    o_cs <= 1'b0;
  endtask : rd
  // ---------------------------------------------------------------
  // Start strobe and conversion clock
  // ---------------------------------------------------------------
  task automatic strobe();
    @(posedge i_ref_clk);
    o_conv <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    o_conv <= 1'b1;
  endtask : strobe
  task automatic clk_edges(input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      o_conv <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      o_conv <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
    end
  endtask : clk_edges
endmodule : adccf_host_model

// >>> tb/adccf_top_test.sv
// Self-checking bench for the conversion control block
module adccf_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import adccf_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [47:0] smp = '0;
  wire conv, cs_n, cs, wr_n, rd_n, oe_n, hold, osc, busy, flag;
  wire [11:0] din, dout;
  logic [11:0] q;
  int mismatches = 0;
  int cmp_count = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  adccf_host_model host (.i_ref_clk(i_ref_clk), .i_q(dout), .o_conv(conv), .o_cs_n(cs_n), .o_cs(cs),
    .o_wr_n(wr_n), .o_rd_n(rd_n), .o_data(din));
  adccf_top uut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_conversion_clock_input(conv),
    .i_select_low_active_n(cs_n), .i_select_high_active(cs), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_data(din),
    .o_data(dout), .o_data_oe_n(oe_n), .i_sample_data(smp), .o_hold(hold), .o_osc_enable(osc),
    .o_conv_busy(busy), .o_result_ready_flag(flag));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  function automatic logic [11:0] val(input int ch, input int k);
    return {ch[3:0], k[7:0]};
  endfunction : val
  task automatic load(input int k);
    smp <= {val(3, k), val(2, k), val(1, k), val(0, k)};
  endtask : load
  task automatic wait_idle();
    int i;
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge i_ref_clk);
    if (i == 300) begin
      chk(12'h0, 12'h1, "busy timeout");
      end_sim();
    end
  endtask : wait_idle
  task automatic start_single(input int k);
    int i;
    load(k);
    fork
      host.strobe();
      begin
        for (i = 0; i < 4 && hold !== 1'b1; i++) begin
          @(posedge i_ref_clk);
          #1;
        end
        chk({11'h0, hold}, 12'h1, "hold pulse");
        chk({11'h0, osc}, 12'h1, "oscillator on");
        @(posedge i_ref_clk);
        #1;
        chk({11'h0, hold}, 12'h0, "hold one cycle");
      end
    join
    wait_idle();
  endtask : start_single
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({11'h0, flag}, 12'h1, "flag at reset");
    chk({11'h0, oe_n}, 12'h1, "bus released");
    chk({11'h0, osc}, 12'h0, "osc at reset");
    chk({11'h0, busy}, 12'h0, "busy at reset");
  endtask : t_reset
  task automatic t_single();
    host.wr(12'h08F, 1'b1, 1'b1);
    host.wr(12'h08F, 1'b0, 1'b0);
    start_single(8'h11);
    host.rd(q);
    chk(q, val(0, 8'h11), "single result");
    host.rd(q);
    chk(q, 12'h000, "empty read");
  endtask : t_single
  task automatic t_diff();
    host.wr(12'h0A3);
    start_single(8'h22);
    host.rd(q);
    chk(q, val(0, 8'h22), "diff pair result");
    host.rd(q);
    chk(q, 12'h000, "diff pair one word");
  endtask : t_diff
  task automatic t_fill();
    host.wr(12'h08F);
    host.wr(12'h43D);
    #1;
    chk({11'h0, flag}, 12'h0, "flag below level");
    for (int k = 0; k < 4; k++) start_single(8'h40 + k);
    #1;
    chk({11'h0, flag}, 12'h1, "flag at full");
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 4; c++) begin
        host.rd(q);
        chk(q, val(c, 8'h40 + k), "scan order");
        if (k == 0 && c == 0) begin
          #1;
          chk({11'h0, flag}, 12'h0, "flag after pop");
        end
      end
    end
    host.rd(q);
    chk(q, 12'h000, "sixteen words only");
  endtask : t_fill
  task automatic t_cont();
    int i;
    host.wr(12'h400);
    host.wr(12'h011);
    load(8'h5A);
    repeat (2) @(posedge i_ref_clk);
    chk({11'h0, osc}, 12'h0, "osc off continuous");
    host.clk_edges(7);
    chk({11'h0, osc}, 12'h0, "osc stays off");
    wait_idle();
    host.rd(q);
    chk(q, val(0, 8'h5A), "continuous result");
    host.wr(12'h402);
    load(8'h6B);
    fork
      host.clk_edges(7);
      begin
        for (i = 0; i < 60 && flag !== 1'b0; i++) begin
          @(posedge i_ref_clk);
          #1;
        end
        chk({11'h0, flag}, 12'h0, "pulse flag low");
        @(posedge i_ref_clk);
        #1;
        chk({11'h0, flag}, 12'h1, "pulse flag one cycle");
      end
    join
    wait_idle();
    host.wr(12'h440);
    host.rd(q);
    chk(q, 12'h000, "flushed");
  endtask : t_cont
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    t_reset();
    t_single();
    t_diff();
    t_fill();
    t_cont();
    end_sim();
  end
endmodule : adccf_top_test
